// *** include/rtcw_pkg.sv ***
// shared constants for the clock sram and its bus controller
package rtcw_pkg;
    localparam int          ADDR_W      = 15;
    localparam int          DATA_W      = 8;
    localparam int          MCLK_HZ     = 25_000_000;
    localparam int          MCLK_NS     = 40;
    // clock area: control byte then seven time bytes
    localparam logic [14:0] CLK_BASE    = 15'h7FF8;
    localparam logic [14:0] TIME_BASE   = 15'h7FF9;
    localparam int          NREG        = 7;
    localparam int          FREEZE_BIT  = 6;
    localparam int          LOAD_BIT    = 7;
    localparam int          IDX_DAY     = 3;
    localparam int          IDX_DATE    = 4;
    localparam int          IDX_MONTH   = 5;
    localparam int          IDX_YEAR    = 6;
    localparam logic [6:0][7:0] FIELD_MASK = {8'hFF, 8'h1F, 8'h3F, 8'h07, 8'h3F, 8'h7F, 8'h7F};
    localparam logic [6:0][7:0] FIELD_LO   = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    localparam logic [6:0][7:0] FIELD_HI   = {8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'h59};
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    // strobe timing in ns and in mclk cycles (least times round up)
    localparam int          T_WLWH_NS   = 50;
    localparam int          T_AVQV_NS   = 70;
    localparam int          T_AVAV_NS   = 70;
    localparam int          DEV_LAT     = 2;
    localparam int          WR_CYC      = (T_WLWH_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int          RD_CYC      = (T_AVQV_NS + MCLK_NS - 1) / MCLK_NS + DEV_LAT;
    localparam int          REC_CYC     = (T_AVAV_NS + MCLK_NS - 1) / MCLK_NS;
    // controller registers on the ahb-lite side
    localparam logic [7:0]  R_ADDR      = 8'h00;
    localparam logic [7:0]  R_WDATA     = 8'h04;
    localparam logic [7:0]  R_CMD       = 8'h08;
    localparam logic [7:0]  R_STATUS    = 8'h0C;
    localparam logic [7:0]  R_RDATA     = 8'h10;
    localparam int          CMD_GO      = 0;
    localparam int          CMD_READ    = 1;
    localparam int          ST_BUSY     = 0;
    localparam int          ST_DONE     = 1;
endpackage

// *** include/rtcw_if.sv ***
// async memory port between controller and clock sram
`timescale 1ns/1ps
`default_nettype none
interface rtcw_if;
    import rtcw_pkg::*;
    logic               ce_n;
    logic               we_n;
    logic               oe_n;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  host_dq;
    logic               host_dq_oe;
    logic [DATA_W-1:0]  dev_dq;
    logic               dev_dq_oe;
    logic [DATA_W-1:0]  dq;
    // bus level; an undriven bus reads as pulled up
    assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : 8'hFF);
    modport dev  (input ce_n, we_n, oe_n, addr, dq, output dev_dq, dev_dq_oe);
    modport host (input dq, output ce_n, we_n, oe_n, addr, host_dq, host_dq_oe);
endinterface
`default_nettype wire

// *** verilog/rtcw_sram.sv ***
// clock sram: async write port, power-fail protect, halt and load of clock copies
`timescale 1ns/1ps
`default_nettype none
module rtcw_sram
    import rtcw_pkg::*;
#(
    parameter int SEC_CYCLES = MCLK_HZ,
    parameter int RECOV_CYC  = 16
)(
    input  wire logic mclk,
    input  wire logic rst,
    rtcw_if.dev       bus,
    input  wire logic power_fail,
    output logic      write_blocked,
    output logic      sec_tick
);
    typedef struct packed {
        logic                 wr_act;
        logic [ADDR_W-1:0]    waddr;
        logic [DATA_W-1:0]    wdata;
        logic [DATA_W-1:0]    rd;
        logic [7:0]           ctrl;
        logic [6:0][7:0]      copy;
        logic [6:0][7:0]      cnt;
        logic [31:0]          pre;
        logic [15:0]          recov;
        logic                 tick;
    } rtcw_dev_t;

    rtcw_dev_t              q;
    rtcw_dev_t              d;
    logic [DATA_W-1:0]      mem [0:(1<<ADDR_W)-1];
    logic                   mem_we;
    logic                   blocked;
    logic                   act;

    // ************************************************************
    // bcd helpers
    // ************************************************************
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                           input logic [7:0] hi);
        if (v >= hi)
            return {1'b1, lo};
        if (v[3:0] >= 4'h9)
            return {1'b0, v[7:4] + 4'h1, 4'h0};
        return {1'b0, v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
        logic [3:0] m4;
        m4 = 4'({1'b0, yr[7:4], 1'b0} + {4'h0, yr[3:0]});
        if (mon == 8'h02)
            return (m4[1:0] == 2'b00) ? 8'h29 : 8'h28;
        if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
            return 8'h30;
        return 8'h31;
    endfunction

    function automatic logic [6:0][7:0] advance(input logic [6:0][7:0] c);
        logic [6:0][7:0] n;
        logic [6:0]      cy;
        logic [8:0]      r;
        logic [7:0]      hi;
        logic            cin;
        n   = c;
        cy  = '0;
        cin = 1'b1;
        for (int i = 0; i < NREG; i++)
        begin
            // date follows the hour carry, not the day-of-week wrap
            if (i == IDX_DATE)
                cin = cy[IDX_DAY-1];
            hi  = (i == IDX_DATE) ? month_len(c[IDX_MONTH] & FIELD_MASK[IDX_MONTH],
                                              c[IDX_YEAR]) : FIELD_HI[i];
            r   = bcd_inc(c[i] & FIELD_MASK[i], FIELD_LO[i], hi);
            if (cin)
            begin
                n[i]  = (c[i] & ~FIELD_MASK[i]) | (r[7:0] & FIELD_MASK[i]);
                cy[i] = r[8];
            end
            cin = cy[i];
        end
        return n;
    endfunction

    // clock area decode, shared by the write and read paths
    localparam logic [1:0] AREA_RAM  = 2'h0;
    localparam logic [1:0] AREA_CTRL = 2'h1;
    localparam logic [1:0] AREA_TIME = 2'h2;

    function automatic logic [1:0] area(input logic [ADDR_W-1:0] a);
        if (a == CLK_BASE)
            return AREA_CTRL;
        if (a >= TIME_BASE)
            return AREA_TIME;
        return AREA_RAM;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        d       = q;
        mem_we  = 1'b0;
        // deselected while failing and during the recovery wait
        blocked = power_fail | (q.recov != '0);
        if (power_fail)
            d.recov = 16'(RECOV_CYC);
        else if (q.recov != '0)
            d.recov = q.recov - 16'h0001;
        act      = ~bus.ce_n & ~bus.we_n & ~blocked;
        d.wr_act = act;
        if (act && !q.wr_act)
            d.waddr = bus.addr;
        if (act)
            d.wdata = bus.dq;
        // free-running prescaler and counters, untouched by halts
        d.tick = 1'b0;
        if (q.pre >= 32'(SEC_CYCLES - 1))
        begin
            d.pre  = '0;
            d.tick = 1'b1;
            d.cnt  = advance(q.cnt);
        end
        else
            d.pre = q.pre + 32'h1;
        // whole-set copy in one cycle; halt bits seen only as stored
        if (d.tick && !q.ctrl[FREEZE_BIT] && !q.ctrl[LOAD_BIT])
            d.copy = d.cnt;
        // a write lands when the strobe pair first goes inactive; a
        // power fail drops the write entirely so nothing is corrupted
        if (q.wr_act && !act && !blocked)
        begin
            if (area(q.waddr) == AREA_CTRL)
            begin
                d.ctrl = q.wdata;
                if (q.ctrl[LOAD_BIT] && !q.wdata[LOAD_BIT])
                begin
                    d.cnt = q.copy;
                    d.pre = '0;
                end
            end
            else if (area(q.waddr) == AREA_TIME)
                d.copy[3'(q.waddr - TIME_BASE)] = q.wdata;
            else
                mem_we = 1'b1;
        end
        // read data trails the address by one cycle
        if (area(bus.addr) == AREA_CTRL)
            d.rd = q.ctrl;
        else if (area(bus.addr) == AREA_TIME)
            d.rd = q.copy[3'(bus.addr - TIME_BASE)];
        else
            d.rd = mem[bus.addr];
    end

    // ************************************************************
    // registers and array
    // ************************************************************
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            q      <= '0;
            q.ctrl <= CTRL_RESET;
        end
        else
            q <= d;
    end

    // array has no reset: contents survive like backed-up cells
    always_ff @(posedge mclk)
    begin
        if (mem_we)
            mem[q.waddr] <= q.wdata;
    end

    // write strobe low or power fail floats the outputs at once
    assign bus.dev_dq_oe = ~bus.ce_n & ~bus.oe_n & bus.we_n & ~q.wr_act & ~blocked;
    assign bus.dev_dq    = q.rd;
    assign write_blocked = blocked;
    assign sec_tick      = q.tick;
endmodule // rtcw_sram
`default_nettype wire

// *** verilog/rtcw_ctrl.sv ***
// ahb-lite controller that runs single strobe cycles on the clock sram
`timescale 1ns/1ps
`default_nettype none
module rtcw_ctrl
    import rtcw_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    rtcw_if.host             bus
);
    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_SETUP = 5'b00010,
        S_PULSE = 5'b00100,
        S_HOLD  = 5'b01000,
        S_REC   = 5'b10000
    } rtcw_st_t;

    typedef struct packed {
        rtcw_st_t             st;
        logic [3:0]           n;
        logic                 ap_wr;
        logic [7:0]           ap_addr;
        logic [ADDR_W-1:0]    addr;
        logic [DATA_W-1:0]    wdata;
        logic [DATA_W-1:0]    rdata;
        logic                 rd_op;
        logic                 done;
        logic                 ce_n;
        logic                 we_n;
        logic                 oe_n;
        logic                 drive;
    } rtcw_host_t;

    rtcw_host_t q;
    rtcw_host_t d;
    logic       go;

    // ************************************************************
    // bus slave and strobe sequencer
    // ************************************************************
    always_comb
    begin
        d  = q;
        go = 1'b0;
        if (hready)
        begin
            d.ap_wr   = hsel & htrans[1] & hwrite;
            d.ap_addr = haddr[7:0];
        end
        if (q.ap_wr)
        begin
            case (q.ap_addr)
                R_ADDR:  d.addr  = hwdata[ADDR_W-1:0];
                R_WDATA: d.wdata = hwdata[DATA_W-1:0];
                R_CMD:
                begin
                    // ignored while a cycle runs
                    if (hwdata[CMD_GO] && q.st == S_IDLE)
                    begin
                        go      = 1'b1;
                        d.rd_op = hwdata[CMD_READ];
                        d.done  = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        case (q.st)
            S_IDLE:
            begin
                if (go)
                begin
                    d.st    = S_SETUP;
                    d.ce_n  = 1'b0;
                    d.oe_n  = ~d.rd_op;
                    d.drive = ~d.rd_op;
                end
            end
            S_SETUP:
            begin
                d.st   = S_PULSE;
                d.we_n = q.rd_op;
                d.n    = 4'(q.rd_op ? RD_CYC - 1 : WR_CYC - 1);
            end
            S_PULSE:
            begin
                if (q.n != 4'h0)
                    d.n = q.n - 4'h1;
                else
                begin
                    // write ends by the strobe; select stays for hold
                    d.st    = S_HOLD;
                    d.we_n  = 1'b1;
                    d.rdata = bus.dq;
                end
            end
            S_HOLD:
            begin
                d.st    = S_REC;
                d.ce_n  = 1'b1;
                d.oe_n  = 1'b1;
                d.n     = 4'(REC_CYC - 1);
            end
            S_REC:
            begin
                d.drive = 1'b0;
                if (q.n != 4'h0)
                    d.n = q.n - 4'h1;
                else
                begin
                    d.st   = S_IDLE;
                    d.done = 1'b1;
                end
            end
            default: d.st = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            q      <= '0;
            q.st   <= S_IDLE;
            q.ce_n <= 1'b1;
            q.we_n <= 1'b1;
            q.oe_n <= 1'b1;
        end
        else
            q <= d;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_comb
    begin
        case (q.ap_addr)
            R_ADDR:   hrdata = {17'h0, q.addr};
            R_WDATA:  hrdata = {24'h0, q.wdata};
            R_STATUS: hrdata = {30'h0, q.done, q.st != S_IDLE};
            R_RDATA:  hrdata = {24'h0, q.rdata};
            default:  hrdata = 32'h0;
        endcase
    end

    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign bus.ce_n       = q.ce_n;
    assign bus.we_n       = q.we_n;
    assign bus.oe_n       = q.oe_n;
    assign bus.addr       = q.addr;
    assign bus.host_dq    = q.wdata;
    assign bus.host_dq_oe = q.drive;
endmodule // rtcw_ctrl
`default_nettype wire

// *** test/rtcw_monitor.sv ***
// concurrent checks on the memory port between controller and clock sram
`timescale 1ns/1ps
`default_nettype none
module rtcw_monitor #(
    parameter int SEC_CYCLES = 200
)(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        ce_n,
    input wire logic        we_n,
    input wire logic        oe_n,
    input wire logic [14:0] addr,
    input wire logic [7:0]  host_dq,
    input wire logic        host_dq_oe,
    input wire logic        dev_dq_oe,
    input wire logic        power_fail,
    input wire logic        write_blocked,
    input wire logic        sec_tick
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    int   gap_q;
    logic seen_q;
    // gap since last update; a load restart can only lengthen it
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            gap_q  <= 0;
            seen_q <= 1'b0;
        end
        else
        begin
            gap_q  <= sec_tick ? 0 : gap_q + 1;
            seen_q <= seen_q | sec_tick;
        end
    end
    sequence wr_pulse;
        !we_n ##1 we_n;
    endsequence
    chk_wr_floats: assert property (!we_n |-> !dev_dq_oe)
        else $error("sram drives bus during write strobe");
    chk_desel_floats: assert property (ce_n |-> !dev_dq_oe)
        else $error("sram drives bus while deselected");
    chk_pf_floats: assert property (power_fail |-> !dev_dq_oe && write_blocked)
        else $error("power fail not floating or blocking");
    chk_recov_holds: assert property ($fell(power_fail) |-> write_blocked [*8])
        else $error("write block dropped too early");
    chk_wr_pulse: assert property ($fell(we_n) |-> !ce_n ##1 wr_pulse)
        else $error("write strobe shape wrong");
    chk_addr_held: assert property (!ce_n && $past(!ce_n) |-> $stable(addr))
        else $error("address moved during access");
    chk_data_held: assert property ($rose(we_n) |-> host_dq_oe && $stable(host_dq) && !ce_n)
        else $error("write data not held at strobe end");
    chk_oe_high: assert property (!we_n |-> oe_n)
        else $error("output enable low in write");
    chk_tick_gap: assert property (sec_tick && seen_q |-> gap_q >= SEC_CYCLES - 1)
        else $error("copy update too early");
    chk_tick_alive: assert property (gap_q < 2 * SEC_CYCLES)
        else $error("copy updates stopped");
endmodule // rtcw_monitor
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench: ahb controller driving the clock sram
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rtcw_pkg::*;
    ;
    localparam int SEC = 200;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        power_fail = 1'b0;
    logic        write_blocked;
    logic        sec_tick;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic [14:0] a;
    logic [7:0]  d;
    logic [7:0]  q;
    int          error_cnt = 0;
    int          checked = 0;
    always #20 mclk = ~mclk;
    rtcw_if rtcw_if_inst ();
    rtcw_sram #(.SEC_CYCLES(SEC), .RECOV_CYC(16)) rtcw_sram_inst (.mclk(mclk), .rst(rst),
        .bus(rtcw_if_inst), .power_fail(power_fail), .write_blocked(write_blocked),
        .sec_tick(sec_tick));
    rtcw_ctrl rtcw_ctrl_inst (.mclk(mclk), .rst(rst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .bus(rtcw_if_inst));
    rtcw_monitor #(.SEC_CYCLES(SEC)) rtcw_monitor_inst (.mclk(mclk), .rst(rst),
        .ce_n(rtcw_if_inst.ce_n), .we_n(rtcw_if_inst.we_n), .oe_n(rtcw_if_inst.oe_n),
        .addr(rtcw_if_inst.addr), .host_dq(rtcw_if_inst.host_dq),
        .host_dq_oe(rtcw_if_inst.host_dq_oe), .dev_dq_oe(rtcw_if_inst.dev_dq_oe),
        .power_fail(power_fail), .write_blocked(write_blocked), .sec_tick(sec_tick));
    // ****************************************
    // helpers
    // ****************************************
    task automatic complete_run();
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // ready is sampled at the edge; a hang is cut after a few cycles
    task automatic hwait();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            error_cnt++;
            complete_run();
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                       output logic [31:0] rd);
        htrans <= 2'b10;
        haddr  <= {24'h0, ad};
        hwrite <= wr;
        hwait();
        htrans <= 2'b00;
        hwdata <= wd;
        hwait();
        rd = hrdata;
    endtask
    task automatic mem(input logic rd_op, input logic [14:0] ad, input logic [7:0] wd,
                       output logic [7:0] rq);
        logic [31:0] s;
        int          n;
        ahb(1'b1, R_ADDR, {17'h0, ad}, s);
        ahb(1'b1, R_WDATA, {24'h0, wd}, s);
        ahb(1'b1, R_CMD, {30'h0, rd_op, 1'b1}, s);
        n = 0;
        do
        begin
            ahb(1'b0, R_STATUS, 32'h0, s);
            n++;
        end
        while (s[ST_DONE] !== 1'b1 && n < 40);
        if (s[ST_DONE] !== 1'b1)
        begin
            error_cnt++;
            complete_run();
        end
        ahb(1'b0, R_RDATA, 32'h0, s);
        rq = s[7:0];
    endtask
    task automatic wait_tick();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (sec_tick !== 1'b1 && n < 3 * SEC);
        if (sec_tick !== 1'b1)
        begin
            error_cnt++;
            complete_run();
        end
    endtask
    function automatic logic [7:0] bcd_add(input logic [7:0] v, input int n);
        logic [7:0] s;
        s = v;
        repeat (n) s = (s[3:0] == 4'h9) ? {s[7:4] + 4'h1, 4'h0} : s + 8'h01;
        return s;
    endfunction
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'h8F98));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        ahb(1'b0, 8'h20, 32'h0, r);
        check(r, 32'h0); // unmapped offset reads zero
        check({31'h0, hresp}, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7FF7 : 15'($urandom_range(32'h7FF7));
            d = 8'($urandom);
            mem(1'b0, a, d, q);
            mem(1'b1, a, 8'h00, q);
            check({24'h0, q}, {24'h0, d});
        end
        mem(1'b0, CLK_BASE, 8'h80, q);
        mem(1'b0, TIME_BASE, 8'h30, q);
        mem(1'b1, CLK_BASE, 8'h00, q);
        check({24'h0, q}, 32'h80);
        wait_tick();
        mem(1'b1, TIME_BASE, 8'h00, q);
        check({24'h0, q}, 32'h30);
        mem(1'b0, CLK_BASE, 8'h00, q);
        wait_tick();
        mem(1'b1, TIME_BASE, 8'h00, q);
        check({24'h0, q}, {24'h0, bcd_add(8'h30, 1)});
        mem(1'b0, CLK_BASE, 8'h40, q);
        wait_tick();
        wait_tick();
        mem(1'b1, TIME_BASE, 8'h00, q);
        check({24'h0, q}, {24'h0, bcd_add(8'h30, 1)});
        mem(1'b0, CLK_BASE, 8'h00, q);
        wait_tick();
        mem(1'b1, TIME_BASE, 8'h00, q);
        check({24'h0, q}, {24'h0, bcd_add(8'h30, 4)});
        a = 15'($urandom_range(32'h7FF7));
        mem(1'b0, a, 8'h5A, q);
        mem(1'b0, a ^ 15'h0001, 8'h96, q);
        // cut the supply while the strobe pair is active
        fork
            mem(1'b0, a, 8'hA5, q);
            begin
                for (int i = 0; i < 40 && rtcw_if_inst.we_n !== 1'b0; i++)
                    @(posedge mclk);
                check({31'h0, rtcw_if_inst.we_n}, 32'h0);
                power_fail <= 1'b1;
            end
        join
        mem(1'b1, a, 8'h00, q);
        check({24'h0, q}, 32'hFF);
        power_fail <= 1'b0;
        mem(1'b0, a, 8'hC3, q);
        for (int i = 0; i < 40 && write_blocked !== 1'b0; i++)
            @(posedge mclk);
        check({31'h0, write_blocked}, 32'h0);
        mem(1'b1, a, 8'h00, q);
        check({24'h0, q}, 32'h5A);
        mem(1'b1, a ^ 15'h0001, 8'h00, q);
        check({24'h0, q}, 32'h96);
        mem(1'b0, a, 8'h3C, q);
        mem(1'b1, a, 8'h00, q);
        check({24'h0, q}, 32'h3C);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
